// ### logic/swv_pkg.sv
// package: constants and types for the stop wake / watchdog / supply monitor block
package swv_pkg;
	// register offsets inside expanded register bank d
	localparam logic [7:0] SUPPLY_VOLTAGE_DETECT_OFS = 8'h0c;
	localparam logic [7:0] STOP_WAKE_SOURCE_TWO_OFS = 8'h0d;
	localparam logic [7:0] WATCHDOG_MODE_OFS = 8'h0f;
	// supply_voltage_detect fields
	localparam int VDET_EN_BIT = 0;
	localparam int VDET_LOW_BIT = 1;
	localparam int VDET_HIGH_BIT = 2;
	// stop_wake_source_two fields
	localparam int SWK_SRC_LSB = 2;
	localparam int SWK_SRC_MSB = 4;
	localparam int SWK_LEVEL_BIT = 6;
	// watchdog_mode fields
	localparam int WDOG_SEL_LSB = 0;
	localparam int WDOG_SEL_MSB = 1;
	localparam int WDOG_HALT_BIT = 2;
	// reset values
	localparam logic [2:0] SWK_SRC_RESET = 3'h0;
	localparam logic SWK_LEVEL_RESET = 1'b0;
	localparam logic VDET_EN_RESET = 1'b0;
	localparam logic [1:0] WDOG_SEL_RESET = 2'h0;
	localparam logic WDOG_HALT_RESET = 1'b1;
	// timing: clock rate and documented times
	localparam int CLK_KHZ = 10000;
	localparam int WDOG_T0_US = 5000;
	localparam int WDOG_T1_US = 10000;
	localparam int WDOG_T2_US = 20000;
	localparam int WDOG_T3_US = 80000;
	localparam int POR_DELAY_US = 2500;
	// least times round up to whole cycles
	localparam int WDOG_T0_CYC = (WDOG_T0_US * CLK_KHZ + 999) / 1000;
	localparam int WDOG_T1_CYC = (WDOG_T1_US * CLK_KHZ + 999) / 1000;
	localparam int WDOG_T2_CYC = (WDOG_T2_US * CLK_KHZ + 999) / 1000;
	localparam int WDOG_T3_CYC = (WDOG_T3_US * CLK_KHZ + 999) / 1000;
	localparam int POR_DELAY_CYC = (POR_DELAY_US * CLK_KHZ + 999) / 1000;
	localparam int WDOG_CNT_W = 20;
	// secondary wake source codes
	typedef enum logic [2:0] {
		SRC_NONE = 3'h0,
		SRC_NAND_P2LO = 3'h1,
		SRC_NAND_P2 = 3'h2,
		SRC_NOR_P3 = 3'h3,
		SRC_NAND_P3 = 3'h4,
		SRC_NOR_P3P0 = 3'h5,
		SRC_NAND_P3P0 = 3'h6,
		SRC_NAND_P3P2 = 3'h7
	} swv_src_t;
	// wake sequencer states
	typedef enum logic {ST_IDLE, ST_DELAY} swv_state_t;
endpackage

// ### logic/swv_wake_if.sv
// interface: secondary wake gate control, pins and result
`timescale 1ns/100ps
`default_nettype none
interface swv_wake_if;
	import swv_pkg::*;
	swv_src_t source;
	logic level;
	logic [7:0] p0, p2, p3;
	logic [7:0] p0_out, p2_out, p3_out;
	logic wake;
	modport gate (input source, level, p0, p2, p3, p0_out, p2_out, p3_out, output wake);
	modport ctrl (output source, level, p0, p2, p3, p0_out, p2_out, p3_out, input wake);
endinterface
`default_nettype wire

// ### logic/swv_wake_gate.sv
// module: secondary stop-mode wake combination of port pins
`timescale 1ns/100ps
`default_nettype none
module swv_wake_gate
	import swv_pkg::*;
(
	// clock and reset, used by the checks only
	input wire logic i_clock,
	input wire logic i_nrst,
	// wake gate signals
	swv_wake_if.gate w
);
	logic nand_p2lo, nand_p2, nor_p3, nand_p3, nor_p3p0, nand_p3p0, nand_p3p2;
	logic gate_out;
	logic [4:0] mix0, mix0_out;
	logic [5:0] mix2, mix2_out;

	// output pins are neutral: 1 into a nand, 0 into a nor
	assign mix0 = {w.p3[3:1], w.p0[7], w.p0[0]};
	assign mix0_out = {w.p3_out[3:1], w.p0_out[7], w.p0_out[0]};
	assign mix2 = {w.p3[3:1], w.p2[2:0]};
	assign mix2_out = {w.p3_out[3:1], w.p2_out[2:0]};
	assign nand_p2lo = ~&(w.p2[3:0] | w.p2_out[3:0]); // RULE_02 RULE_05
	assign nand_p2 = ~&(w.p2 | w.p2_out); // RULE_02 RULE_05
	assign nor_p3 = ~|(w.p3[3:1] & ~w.p3_out[3:1]); // RULE_03 RULE_05
	assign nand_p3 = ~&(w.p3[3:1] | w.p3_out[3:1]); // RULE_03 RULE_05
	assign nor_p3p0 = ~|(mix0 & ~mix0_out); // RULE_04 RULE_05
	assign nand_p3p0 = ~&(mix0 | mix0_out); // RULE_04 RULE_05
	assign nand_p3p2 = ~&(mix2 | mix2_out); // RULE_04 RULE_05

	// source select; code 000 leaves only power-on reset
	always_comb begin
		unique case (w.source)
			SRC_NONE: gate_out = 1'b0; // RULE_01
			SRC_NAND_P2LO: gate_out = nand_p2lo;
			SRC_NAND_P2: gate_out = nand_p2;
			SRC_NOR_P3: gate_out = nor_p3;
			SRC_NAND_P3: gate_out = nand_p3;
			SRC_NOR_P3P0: gate_out = nor_p3p0;
			SRC_NAND_P3P0: gate_out = nand_p3p0;
			SRC_NAND_P3P2: gate_out = nand_p3p2;
		endcase
	end

	// level bit sits at the xor input
	assign w.wake = (w.source != SRC_NONE) & (gate_out ^ w.level); // RULE_06 RULE_19 RULE_01

	src_none_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_01
		w.source == SRC_NONE |-> !w.wake) else $error("wake with source none");
	nand_low_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_02
		(w.source == SRC_NAND_P2LO && !w.level && w.p2_out == 8'h00 && w.p2[3:0] != 4'hf)
		|-> w.wake) else $error("port 2 low nibble nand missed");
	nor_p3_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_03
		(w.source == SRC_NOR_P3 && !w.level && w.p3_out == 8'h00)
		|-> w.wake == (w.p3[3:1] == 3'h0)) else $error("port 3 nor wrong");
	mix_p2_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_04
		(w.source == SRC_NAND_P3P2 && !w.level && w.p2_out == 8'h00 && !w.p2[0])
		|-> w.wake) else $error("port 3 and 2 nand missed");
	out_excl_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_05
		(((w.source == SRC_NAND_P2LO && w.p2_out[3:0] == 4'hf)
		|| (w.source == SRC_NAND_P2 && w.p2_out == 8'hff)) && !w.level)
		|-> !w.wake) else $error("output pin used as wake source");
	level_inv_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_06
		(w.source == SRC_NAND_P2 && w.level && w.p2_out == 8'h00 && w.p2 == 8'hff)
		|-> w.wake) else $error("high level wake missed");
endmodule
`default_nettype wire

// ### logic/swv_power_ctrl.sv
// module: stop wake select, watchdog mode and supply voltage detection
//
// Behaviour
// [RULE_01] source 000: no pin wake, POR only
// [RULE_02] 001/010: NAND port 2 low/all bits
// [RULE_03] 011/100: NOR/NAND of port 3 bits 1-3
// [RULE_04] 101/110/111: mixed port 3, 0, 2 gates
// [RULE_05] pins driven as outputs are ignored
// [RULE_06] level bit inverts gate: 0 low, 1 high
// [RULE_07] source and level bits are write-only
// [RULE_08] reset sets defaults; wake keeps contents
// [RULE_09] primary or secondary event ends stop
// [RULE_10] watchdog select: 5, 10, 20, 80 ms
// [RULE_11] halt bit keeps watchdog counting, default 1
// [RULE_12] detection only while enable bit set
// [RULE_13] bit 2 set while supply above high
// [RULE_14] bit 1 set while supply below low
// [RULE_15] low flag latches supply request until cleared
// [RULE_16] request served only when mask enables it
// [RULE_17] software enables interrupts before detection enable
// [RULE_18] primary bit 5 picks delay or immediate resume
// [RULE_19] secondary wake is gate xor level in stop
`timescale 1ns/100ps
`default_nettype none
module swv_power_ctrl
	import swv_pkg::*;
#(
	parameter int WDOG_CYC0 = WDOG_T0_CYC,
	parameter int WDOG_CYC1 = WDOG_T1_CYC,
	parameter int WDOG_CYC2 = WDOG_T2_CYC,
	parameter int WDOG_CYC3 = WDOG_T3_CYC,
	parameter int POR_DELAY = POR_DELAY_CYC
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// expanded register file access, bank d
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// port pins and their output configuration (1 = output)
	input wire logic [7:0] i_port0,
	input wire logic [7:0] i_port2,
	input wire logic [7:0] i_port3,
	input wire logic [7:0] i_port0_is_out,
	input wire logic [7:0] i_port2_is_out,
	input wire logic [7:0] i_port3_is_out,
	// power modes and primary wake logic
	input wire logic i_stop_mode,
	input wire logic i_halt_mode,
	input wire logic i_primary_wake,
	input wire logic i_primary_delay_sel,
	output logic o_stop_resume,
	// watchdog
	input wire logic i_watchdog_kick,
	output logic o_watchdog_timeout,
	// supply comparators
	input wire logic i_supply_below_low,
	input wire logic i_supply_above_high,
	// supply interrupt request
	input wire logic i_supply_request_clear,
	input wire logic i_supply_request_enable,
	output logic o_supply_interrupt_request,
	output logic o_supply_interrupt_serve
);
	swv_wake_if wk ();

	swv_src_t wake_src;
	logic wake_level;
	logic vdet_en;
	logic [1:0] wdog_sel;
	logic wdog_halt;
	logic wr_vdet, wr_swk, wr_wdog;
	logic low_flag, high_flag;
	logic wake_any;
	logic [WDOG_CNT_W-1:0] wdog_cnt, wdog_limit;
	logic wdog_run;
	swv_state_t state;
	logic [WDOG_CNT_W-1:0] delay_cnt;
	logic [7:0] next_rdata;

	localparam logic [WDOG_CNT_W-1:0] LIM0 = WDOG_CNT_W'(WDOG_CYC0 - 1);
	localparam logic [WDOG_CNT_W-1:0] LIM1 = WDOG_CNT_W'(WDOG_CYC1 - 1);
	localparam logic [WDOG_CNT_W-1:0] LIM2 = WDOG_CNT_W'(WDOG_CYC2 - 1);
	localparam logic [WDOG_CNT_W-1:0] LIM3 = WDOG_CNT_W'(WDOG_CYC3 - 1);
	localparam logic [WDOG_CNT_W-1:0] DLY_LAST = WDOG_CNT_W'(POR_DELAY - 1);

	// write strobes
	assign wr_vdet = i_reg_wr && (i_reg_addr == SUPPLY_VOLTAGE_DETECT_OFS);
	assign wr_swk = i_reg_wr && (i_reg_addr == STOP_WAKE_SOURCE_TWO_OFS);
	assign wr_wdog = i_reg_wr && (i_reg_addr == WATCHDOG_MODE_OFS);

	// secondary wake select; only a real reset restores it, never a wake
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			wake_src <= swv_src_t'(SWK_SRC_RESET); // RULE_08
			wake_level <= SWK_LEVEL_RESET;
		end else if (wr_swk) begin
			wake_src <= swv_src_t'(i_reg_wdata[SWK_SRC_MSB:SWK_SRC_LSB]);
			wake_level <= i_reg_wdata[SWK_LEVEL_BIT];
		end
	end

	// watchdog mode register
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			wdog_sel <= WDOG_SEL_RESET;
			wdog_halt <= WDOG_HALT_RESET; // RULE_11
		end else if (wr_wdog) begin
			wdog_sel <= i_reg_wdata[WDOG_SEL_MSB:WDOG_SEL_LSB];
			wdog_halt <= i_reg_wdata[WDOG_HALT_BIT];
		end
	end

	// detection enable; flag bits are read-only
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			vdet_en <= VDET_EN_RESET;
		end else if (wr_vdet) begin
			vdet_en <= i_reg_wdata[VDET_EN_BIT];
		end
	end

	// comparators only count while detection is on
	assign low_flag = vdet_en & i_supply_below_low; // RULE_12 RULE_14
	assign high_flag = vdet_en & i_supply_above_high; // RULE_12 RULE_13

	// read mux; write-only register reads as zero
	always_comb begin
		next_rdata = 8'h00;
		unique case (i_reg_addr)
			SUPPLY_VOLTAGE_DETECT_OFS: begin
				next_rdata[VDET_EN_BIT] = vdet_en;
				next_rdata[VDET_LOW_BIT] = low_flag; // RULE_14
				next_rdata[VDET_HIGH_BIT] = high_flag; // RULE_13
			end
			WATCHDOG_MODE_OFS: begin
				next_rdata[WDOG_SEL_MSB:WDOG_SEL_LSB] = wdog_sel;
				next_rdata[WDOG_HALT_BIT] = wdog_halt;
			end
			default: next_rdata = 8'h00; // RULE_07
		endcase
	end

	// read data held until the next read
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			o_reg_rdata <= next_rdata;
		end
	end

	// latched supply request; a new low flag beats a clear in the same cycle
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_supply_interrupt_request <= 1'b0;
		end else if (low_flag) begin
			o_supply_interrupt_request <= 1'b1; // RULE_15
		end else if (i_supply_request_clear) begin
			o_supply_interrupt_request <= 1'b0;
		end
	end

	// enabled request goes to the core; masked it is only a status flag
	assign o_supply_interrupt_serve = o_supply_interrupt_request & i_supply_request_enable; // RULE_16

	// wake gate
	assign wk.source = wake_src;
	assign wk.level = wake_level;
	assign wk.p0 = i_port0;
	assign wk.p2 = i_port2;
	assign wk.p3 = i_port3;
	assign wk.p0_out = i_port0_is_out;
	assign wk.p2_out = i_port2_is_out;
	assign wk.p3_out = i_port3_is_out;

	swv_wake_gate u_gate (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.w(wk.gate)
	);

	// either recovery source ends stop mode
	assign wake_any = i_stop_mode & (i_primary_wake | wk.wake); // RULE_09 RULE_19

	// wake sequencer: optional power-on delay before resume
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state <= ST_IDLE;
			delay_cnt <= '0;
			o_stop_resume <= 1'b0;
		end else begin
			o_stop_resume <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (wake_any) begin
						if (i_primary_delay_sel) begin
							state <= ST_DELAY; // RULE_18
							delay_cnt <= '0;
						end else begin
							o_stop_resume <= 1'b1; // RULE_18
						end
					end
				end
				ST_DELAY: begin
					if (delay_cnt == DLY_LAST) begin
						state <= ST_IDLE;
						o_stop_resume <= 1'b1;
					end else begin
						delay_cnt <= delay_cnt + 1'b1;
					end
				end
			endcase
		end
	end

	// timeout select
	always_comb begin
		unique case (wdog_sel)
			2'h0: wdog_limit = LIM0; // RULE_10
			2'h1: wdog_limit = LIM1;
			2'h2: wdog_limit = LIM2;
			2'h3: wdog_limit = LIM3;
		endcase
	end

	// frozen in stop; in halt only when the halt bit allows
	assign wdog_run = !i_stop_mode && (!i_halt_mode || wdog_halt); // RULE_11

	// watchdog counter; a shorter select takes effect at once
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			wdog_cnt <= '0;
			o_watchdog_timeout <= 1'b0;
		end else begin
			o_watchdog_timeout <= 1'b0;
			if (i_watchdog_kick) begin
				wdog_cnt <= '0;
			end else if (wdog_run) begin
				if (wdog_cnt >= wdog_limit) begin
					wdog_cnt <= '0;
					o_watchdog_timeout <= 1'b1; // RULE_10
				end else begin
					wdog_cnt <= wdog_cnt + 1'b1;
				end
			end
		end
	end

	wo_read_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_07
		(i_reg_rd && i_reg_addr == STOP_WAKE_SOURCE_TWO_OFS) |=> o_reg_rdata == 8'h00)
		else $error("write-only register read back");
	vdet_read_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_12
		(i_reg_rd && i_reg_addr == SUPPLY_VOLTAGE_DETECT_OFS)
		|=> o_reg_rdata[2:1] == $past({high_flag, low_flag}) && o_reg_rdata[7:3] == 5'h00
		&& (o_reg_rdata[2:1] == 2'h0 || o_reg_rdata[0]))
		else $error("detect flags read wrong");
	req_set_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_15
		(vdet_en && i_supply_below_low) |=> o_supply_interrupt_request)
		else $error("low supply request not latched");
	req_hold_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_15
		(o_supply_interrupt_request && !i_supply_request_clear) |=> o_supply_interrupt_request)
		else $error("supply request dropped");
	req_serve_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_16
		o_supply_interrupt_serve |-> o_supply_interrupt_request && i_supply_request_enable)
		else $error("supply request served while masked");
	wake_now_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_18
		(state == ST_IDLE && wake_any && !i_primary_delay_sel) |=> o_stop_resume)
		else $error("immediate resume missing");
	wake_either_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_09
		(state == ST_IDLE && i_stop_mode && i_primary_wake)
		|=> (o_stop_resume || state == ST_DELAY))
		else $error("primary wake ignored");
	halt_freeze_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_11
		(i_halt_mode && !wdog_halt && !i_watchdog_kick) |=> $stable(wdog_cnt))
		else $error("watchdog counted in halt");
	wdog_period_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_10
		o_watchdog_timeout |-> $past(wdog_cnt) >= $past(wdog_limit))
		else $error("watchdog timeout early");
	src_keep_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_08
		(!wr_swk) |=> $stable(wake_src) && $stable(wake_level))
		else $error("wake select changed without write");
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// testbench: register, stop wake, watchdog and supply request checks for swv_power_ctrl
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import swv_pkg::*;
	// shortened counts so every timeout fits in a short run
	localparam int CYC0 = 4;
	localparam int CYC1 = 8;
	localparam int CYC2 = 16;
	localparam int CYC3 = 64;
	localparam int POR_D = 5;
	logic clock, nrst, wr, rd, stop, halt, pwake, dsel, kick, blow, bhigh, rclr, ren;
	logic [7:0] addr, wdata, p0, p2, p3, p0o, p2o, p3o;
	logic [7:0] rdata;
	logic resume, wdto, req, serve;
	int fail_count = 0;
	int total_checks = 0;
	// member pins of each source code, packed as {port0, port2, port3}
	logic [23:0] members [8] = '{24'h000000, 24'h000f00, 24'h00ff00, 24'h00000e,
		24'h00000e, 24'h81000e, 24'h81000e, 24'h00070e};
	int cyc [4] = '{CYC0, CYC1, CYC2, CYC3};

	swv_power_ctrl #(.WDOG_CYC0(CYC0), .WDOG_CYC1(CYC1), .WDOG_CYC2(CYC2), .WDOG_CYC3(CYC3),
		.POR_DELAY(POR_D)) uut (
		.i_clock(clock), .i_nrst(nrst),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdata),
		.i_port0(p0), .i_port2(p2), .i_port3(p3),
		.i_port0_is_out(p0o), .i_port2_is_out(p2o), .i_port3_is_out(p3o),
		.i_stop_mode(stop), .i_halt_mode(halt), .i_primary_wake(pwake),
		.i_primary_delay_sel(dsel), .o_stop_resume(resume),
		.i_watchdog_kick(kick), .o_watchdog_timeout(wdto),
		.i_supply_below_low(blow), .i_supply_above_high(bhigh),
		.i_supply_request_clear(rclr), .i_supply_request_enable(ren),
		.o_supply_interrupt_request(req), .o_supply_interrupt_serve(serve)
	);

	// free-running 10 mhz clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic end_sim();
		if (fail_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// one-cycle strobes; the bus takes each access at the edge after it is driven
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock) begin addr <= a; wdata <= d; wr <= 1'b1; end
		@(posedge clock) wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock) begin addr <= a; rd <= 1'b1; end
		@(posedge clock) rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic do_reset();
		@(posedge clock) nrst <= 1'b0;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
	endtask

	// stop held for one edge only, so a second pulse would show a stuck output
	task automatic wake_try(input int exp_k, input string msg);
		int k;
		int n;
		k = 0;
		n = 0;
		@(posedge clock) stop <= 1'b1;
		for (int i = 1; i <= 12; i++) begin
			@(posedge clock) stop <= 1'b0;
			#1;
			if (resume === 1'b1) begin
				n++;
				if (k == 0) k = i;
			end
		end
		chk(k[7:0], exp_k[7:0], msg);
		chk(n[7:0], (exp_k != 0) ? 8'h01 : 8'h00, "resume pulse count");
	endtask

	task automatic t_reset_values();
		logic [7:0] d;
		reg_rd(SUPPLY_VOLTAGE_DETECT_OFS, d);
		chk(d, 8'h00, "detect reset");
		reg_rd(STOP_WAKE_SOURCE_TWO_OFS, d);
		chk(d, 8'h00, "wake select reads zero");
		reg_rd(WATCHDOG_MODE_OFS, d);
		chk(d, 8'h04, "watchdog mode reset");
		reg_rd(8'h20, d);
		chk(d, 8'h00, "unmapped read");
		chk({7'h00, req}, 8'h00, "request after reset");
	endtask

	// members low / others high must wake, the inverse must not; level flips it
	task automatic t_wake_codes();
		logic [7:0] d;
		for (int c = 0; c < 8; c++) begin
			for (int l = 0; l < 2; l++) begin
				reg_wr(STOP_WAKE_SOURCE_TWO_OFS, {1'b0, l[0], 1'b0, c[2:0], 2'b00});
				@(posedge clock) {p0, p2, p3} <= (l == 1) ? members[c] : ~members[c];
				wake_try((c == 0) ? 0 : 1, "gate wake");
				@(posedge clock) {p0, p2, p3} <= (l == 1) ? ~members[c] : members[c];
				wake_try(0, "gate idle");
			end
		end
		reg_rd(STOP_WAKE_SOURCE_TWO_OFS, d);
		chk(d, 8'h00, "write-only select");
	endtask

	task automatic t_outputs_excluded();
		reg_wr(STOP_WAKE_SOURCE_TWO_OFS, 8'h08);
		@(posedge clock) begin p2 <= 8'h00; p2o <= 8'hff; end
		wake_try(0, "all outputs ignored");
		@(posedge clock) p2o <= 8'hfe;
		wake_try(1, "one input low");
		wake_try(1, "select kept after wake");
		@(posedge clock) begin p2o <= 8'h00; p2 <= 8'hff; end
		// high output pins on ports 0 and 3 must not block a nor wake
		reg_wr(STOP_WAKE_SOURCE_TWO_OFS, 8'h14);
		@(posedge clock) begin p0 <= 8'h80; p3 <= 8'h02; p0o <= 8'h80; p3o <= 8'h02; end
		wake_try(1, "nor ignores outputs");
		@(posedge clock) begin p0 <= 8'hff; p3 <= 8'hff; p0o <= 8'h00; p3o <= 8'h00; end
	endtask

	task automatic t_primary();
		reg_wr(STOP_WAKE_SOURCE_TWO_OFS, 8'h00);
		@(posedge clock) pwake <= 1'b1;
		wake_try(1, "primary immediate");
		@(posedge clock) dsel <= 1'b1;
		wake_try(1 + POR_D, "primary delayed");
		@(posedge clock) begin pwake <= 1'b0; dsel <= 1'b0; end
	endtask

	task automatic wd_meas(output int n);
		n = 0;
		@(posedge clock) kick <= 1'b1;
		@(posedge clock) kick <= 1'b0;
		for (int i = 1; i <= 100; i++) begin
			@(posedge clock);
			#1;
			if (wdto === 1'b1 && n == 0) n = i;
		end
	endtask

	task automatic t_watchdog();
		logic [7:0] d;
		int n;
		for (int s = 0; s < 4; s++) begin
			reg_wr(WATCHDOG_MODE_OFS, {5'h00, 1'b1, s[1:0]});
			reg_rd(WATCHDOG_MODE_OFS, d);
			chk(d, {5'h00, 1'b1, s[1:0]}, "watchdog mode readback");
			wd_meas(n);
			chk(n[7:0], cyc[s][7:0], "watchdog period");
		end
		// halt freezes the count only while the halt bit is clear
		reg_wr(WATCHDOG_MODE_OFS, 8'h00);
		@(posedge clock) halt <= 1'b1;
		wd_meas(n);
		chk(n[7:0], 8'h00, "frozen in halt");
		reg_wr(WATCHDOG_MODE_OFS, 8'h04);
		wd_meas(n);
		chk(n[7:0], CYC0[7:0], "runs in halt");
		@(posedge clock) halt <= 1'b0;
	endtask

	task automatic t_supply();
		logic [7:0] d;
		@(posedge clock) begin blow <= 1'b1; bhigh <= 1'b1; ren <= 1'b1; end
		repeat (3) @(posedge clock);
		#1 chk({7'h00, req}, 8'h00, "no request while disabled");
		reg_rd(SUPPLY_VOLTAGE_DETECT_OFS, d);
		chk(d, 8'h00, "flags quiet while disabled");
		@(posedge clock) bhigh <= 1'b0;
		reg_wr(SUPPLY_VOLTAGE_DETECT_OFS, 8'hff);
		reg_rd(SUPPLY_VOLTAGE_DETECT_OFS, d);
		chk(d, 8'h03, "low flag, flag bits not writable");
		chk({7'h00, req}, 8'h01, "request raised");
		chk({7'h00, serve}, 8'h01, "served when enabled");
		@(posedge clock) ren <= 1'b0;
		#1 chk({6'h00, req, serve}, 8'h02, "masked request is a flag");
		@(posedge clock) begin blow <= 1'b0; bhigh <= 1'b1; end
		reg_rd(SUPPLY_VOLTAGE_DETECT_OFS, d);
		chk(d, 8'h05, "high flag");
		chk({7'h00, req}, 8'h01, "request latched");
		@(posedge clock) rclr <= 1'b1;
		@(posedge clock) rclr <= 1'b0;
		#1 chk({7'h00, req}, 8'h00, "request cleared");
		// a clear in the same cycle as a set must lose
		@(posedge clock) begin blow <= 1'b1; rclr <= 1'b1; end
		@(posedge clock);
		@(posedge clock) begin blow <= 1'b0; rclr <= 1'b0; end
		#1 chk({7'h00, req}, 8'h01, "set beats clear");
		do_reset();
		#1 chk({7'h00, req}, 8'h00, "reset clears request");
		t_reset_values();
	endtask

	// all inputs defined at time zero, reset held from the start
	initial begin
		nrst = 1'b0;
		{wr, rd, stop, halt, pwake, dsel, kick, blow, bhigh, rclr, ren} = '0;
		{addr, wdata, p0o, p2o, p3o} = '0;
		{p0, p2, p3} = 24'hffffff;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		t_reset_values();
		t_wake_codes();
		t_outputs_excluded();
		t_primary();
		t_watchdog();
		t_supply();
		end_sim();
	end
endmodule
`default_nettype wire
